// ### include/mac_control_map.vh
// Register indices, field positions and reset values of the MAC control block
`ifndef MAC_CONTROL_MAP_VH
`define MAC_CONTROL_MAP_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define MAC_CTL_IDX      10'h0E7
`define MAC_ACC0_IDX     10'h0E8
`define MAC_ACC4_IDX     10'h0EC

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define MAC_CTL_RESET    8'h00
`define MAC_IE_BIT       7
`define MAC_FILL_BIT     6
`define MAC_RSH_MSB      5
`define MAC_RSH_LSB      3
`define MAC_WSH_MSB      2
`define MAC_WSH_LSB      0

// ------------------------------------------------------------
// Widths and constant values
// ------------------------------------------------------------
`define MAC_ACC_WIDTH    40
`define MAC_ACC_BYTES    5
`define MAC_ACC_ZERO     40'h0000000000
`define MAC_BYTE_ZERO    8'h00
`define MAC_WORD_ZERO    32'h00000000

`endif

// ### hw/mac_shift_views.v
// Shifted read and write views of the accumulator
`timescale 1ns/1ps
`include "mac_control_map.vh"

module mac_shift_views #(
   parameter WIDTH = `MAC_ACC_WIDTH
) (
   input  wire [WIDTH-1:0] accIn,
   input  wire [WIDTH-1:0] dataIn,
   input  wire [2:0]       readShift,
   input  wire [2:0]       writeShift,
   input  wire             fillBit,
   output wire [WIDTH-1:0] readView,
   output wire [WIDTH-1:0] writeView
);

   // ------------------------------------------------------------
   // Views
   // ------------------------------------------------------------
   wire [WIDTH-1:0] fillMask;

   // Sign copies of the top bit fill vacated upper positions
   assign readView  = $signed(accIn) >>> readShift;

   // Vacated low bits take the fill value, top bits fall off
   assign fillMask  = ~({WIDTH{1'b1}} << writeShift);
   assign writeView = (dataIn << writeShift) | (fillMask & {WIDTH{fillBit}});

endmodule // mac_shift_views

// ### hw/mac_control_and_shift.v
// MAC control register, accumulator byte window and completion interrupt
//
// How it works
// - Any control write clears the whole accumulator.
// - Enable bit arms a completion interrupt request.
// - Fill bit selects ones or zeros.
// - Read shift zero returns accumulator unchanged.
// - Nonzero read shift: arithmetic right shift.
// - Write shift zero stores data unchanged.
// - Nonzero write shift: left shift, fill low.
// - Accumulator seen as five byte registers.
`timescale 1ns/1ps
`include "mac_control_map.vh"

module mac_control_and_shift #(
   parameter ADDR_WIDTH = 12
) (
   input  wire                       sys_clk,
   input  wire                       nrst,
   input  wire                       psel,
   input  wire                       penable,
   input  wire                       pwrite,
   input  wire [ADDR_WIDTH-1:0]      paddr,
   input  wire [31:0]                pwdata,
   output reg  [31:0]                prdata,
   output wire                       pready,
   output wire                       pslverr,
   input  wire                       calcStart,
   input  wire                       calcDone,
   input  wire                       accLoad,
   input  wire [`MAC_ACC_WIDTH-1:0]  accLoadValue,
   output wire [`MAC_ACC_WIDTH-1:0]  accValue,
   output wire                       calcIrq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg  [7:0]                 macControl;
   reg  [`MAC_ACC_WIDTH-1:0]  acc;
   reg  [`MAC_ACC_WIDTH-1:0]  writeImage;
   reg                        irqArmed;
   reg                        irqPending;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire [ADDR_WIDTH-3:0]      wordIdx;
   wire                       hitCtl;
   wire                       hitAcc;
   wire [2:0]                 byteSel;
   wire [ADDR_WIDTH-3:0]      accOffset;
   wire                       access;
   wire                       ctlWrite;
   wire                       accWrite;
   wire                       topRead;
   wire [`MAC_ACC_WIDTH-1:0]  next_writeImage;
   wire [`MAC_ACC_WIDTH-1:0]  readView;
   wire [`MAC_ACC_WIDTH-1:0]  writeView;
   wire [7:0]                 readByte [0:`MAC_ACC_BYTES-1];
   reg  [31:0]                next_prdata;

   assign wordIdx   = paddr[ADDR_WIDTH-1:2];
   assign accOffset = wordIdx - `MAC_ACC0_IDX;
   assign byteSel   = accOffset[2:0];
   assign hitCtl    = (wordIdx == `MAC_CTL_IDX);
   assign hitAcc    = (wordIdx >= `MAC_ACC0_IDX) && (wordIdx <= `MAC_ACC4_IDX);
   assign access    = psel && penable;
   assign ctlWrite  = access && pwrite && hitCtl;
   assign accWrite  = access && pwrite && hitAcc;
   assign topRead   = access && !pwrite && (wordIdx == `MAC_ACC4_IDX);

   // Zero wait states; read data is prepared in the setup cycle
   assign pready    = 1'b1;
   assign pslverr   = access && !(hitCtl || hitAcc);

   // ------------------------------------------------------------
   // Byte lanes
   // ------------------------------------------------------------
   // Bytes written by the CPU are kept unshifted so a later byte
   // does not shift earlier ones a second time
   genvar k;
   generate
      for (k = 0; k < `MAC_ACC_BYTES; k = k + 1) begin : g_byte
         assign next_writeImage[8*k+7:8*k] = (byteSel == k) ?
            pwdata[7:0] : writeImage[8*k+7:8*k];
         assign readByte[k] = readView[8*k+7:8*k];
      end
   endgenerate

   mac_shift_views #(
      .WIDTH      (`MAC_ACC_WIDTH)
   ) u_views (
      .accIn      (acc),
      .dataIn     (next_writeImage),
      .readShift  (macControl[`MAC_RSH_MSB:`MAC_RSH_LSB]),
      .writeShift (macControl[`MAC_WSH_MSB:`MAC_WSH_LSB]),
      .fillBit    (macControl[`MAC_FILL_BIT]),
      .readView   (readView),
      .writeView  (writeView)
   );

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always @* begin
      next_prdata = `MAC_WORD_ZERO;
      if (hitCtl) begin
         next_prdata[7:0] = macControl;
      end else if (hitAcc) begin
         next_prdata[7:0] = readByte[byteSel];
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= `MAC_WORD_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ------------------------------------------------------------
   // Control and accumulator
   // ------------------------------------------------------------
   // A CPU write wins over an engine load in the same cycle
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         macControl <= `MAC_CTL_RESET;
         acc        <= `MAC_ACC_ZERO;
         writeImage <= `MAC_ACC_ZERO;
      end else if (ctlWrite) begin
         macControl <= pwdata[7:0];
         acc        <= `MAC_ACC_ZERO;
         writeImage <= `MAC_ACC_ZERO;
      end else if (accWrite) begin
         writeImage <= next_writeImage;
         acc        <= writeView;
      end else if (accLoad) begin
         acc        <= accLoadValue;
      end
   end

   assign accValue = acc;

   // ------------------------------------------------------------
   // Completion interrupt
   // ------------------------------------------------------------
   // Enable is captured when the calculation starts, so later
   // control writes affect only the next calculation
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irqArmed   <= 1'b0;
         irqPending <= 1'b0;
      end else begin
         if (calcStart) begin
            irqArmed <= macControl[`MAC_IE_BIT];
         end
         if (calcDone && irqArmed) begin
            irqPending <= 1'b1;
         end else if (topRead || ctlWrite) begin
            irqPending <= 1'b0;
         end
      end
   end

   assign calcIrq = irqPending;

endmodule // mac_control_and_shift

// ### dv/mac_ctl_checker.sv
// Assertions on the MAC control block ports
`timescale 1ns/1ps
module mac_ctl_checker #(parameter ADDR_WIDTH = 12) (
   input wire logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr,
   input wire logic calcStart, calcDone, accLoad, calcIrq,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [39:0] accLoadValue, accValue);
   wire       acs = psel & penable;
   wire [9:0] ix = paddr[11:2];
   wire       ctlW = acs & pwrite & (ix == 10'h0E7);
   wire       rdAcc = acs & !pwrite & (ix >= 10'h0E8) & (ix <= 10'h0EC);
   reg  [7:0] ctl;
   reg        arm;
   always @(posedge sys_clk or negedge nrst)
      if (!nrst) begin
         ctl <= 8'h00;
         arm <= 1'b0;
      end else begin
         if (ctlW) ctl <= pwdata[7:0];
         if (calcStart) arm <= ctl[7];
      end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_ctl_clears_acc: assert property (ctlW |=> accValue == 40'h0)
      else $error("acc not cleared");
   chk_irq_cause: assert property ($rose(calcIrq) |-> $past(calcDone))
      else $error("irq without done");
   chk_irq_fires: assert property (calcDone && arm |=> calcIrq)
      else $error("armed irq missing");
   chk_irq_clear: assert property ((ctlW | (rdAcc & ix == 10'h0EC)) & !calcDone |=> !calcIrq)
      else $error("irq not cleared");
   chk_read_view: assert property (rdAcc |-> prdata == {24'h0, 8'((($signed($past(accValue))
      >>> $past(ctl[5:3])) >> (8 * (ix - 10'h0E8))))})
      else $error("shifted read wrong");
   chk_ctl_read: assert property (acs & !pwrite & ix == 10'h0E7 |-> prdata == {24'h0, $past(ctl)})
      else $error("control read wrong");
   chk_unmapped_err: assert property (acs & (ix < 10'h0E7 | ix > 10'h0EC) |->
      pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
   chk_engine_load: assert property (accLoad & !(acs & pwrite) |=> accValue == $past(accLoadValue))
      else $error("engine load lost");
   chk_ready_high: assert property (pready) else $error("pready low");
   cover property (calcIrq);
   cover property (ctlW && pwdata[5:0] == 6'h3F);
   cover property (acs && pslverr);
endmodule // mac_ctl_checker
bind mac_control_and_shift mac_ctl_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_i (.sys_clk, .nrst,
   .psel, .penable, .pwrite, .pready, .pslverr, .calcStart, .calcDone, .accLoad, .calcIrq,
   .paddr, .pwdata, .prdata, .accLoadValue, .accValue);

// ### dv/mac_engine_model.sv
// Behavioural model of the calculation engine
`timescale 1ns/1ps
module mac_engine_model (
   input  wire logic        sys_clk, go,
   input  wire logic [3:0]  gap,
   input  wire logic [39:0] v,
   output logic calcStart = 1'b0, calcDone = 1'b0, accLoad = 1'b0,
   output logic [39:0] accLoadValue = 40'h0);
   // Gap makes the engine prompt or slow
   always begin
      @(posedge sys_clk);
      if (go) begin
         calcStart <= 1'b1;
         @(posedge sys_clk) calcStart <= 1'b0;
         repeat (gap) @(posedge sys_clk);
         accLoad <= 1'b1;
         accLoadValue <= v;
         @(posedge sys_clk) accLoad <= 1'b0;
         calcDone <= 1'b1;
         accLoadValue <= ~v; // Released bus must not show old value
         @(posedge sys_clk) calcDone <= 1'b0;
      end
   end
endmodule // mac_engine_model

// ### dv/mac_control_and_shift_tb.sv
// Testbench of the MAC control block
`timescale 1ns/1ps
module mac_control_and_shift_tb;
   logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rs = 36469;
   logic [39:0] v = 0, img, accLoadValue, accValue;
   logic [7:0] rd, ctl;
   logic err = 0;
   logic [3:0] gap = 0;
   wire pready, pslverr, calcStart, calcDone, accLoad, calcIrq;
   integer err_count = 0, comparisons = 0, i, k;
   mac_control_and_shift mac_control_and_shift_i (.sys_clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .calcStart, .calcDone, .accLoad,
      .accLoadValue, .accValue, .calcIrq);
   mac_engine_model mac_engine_model_i (.sys_clk, .go, .gap, .v, .calcStart, .calcDone,
      .accLoad, .accLoadValue);
   initial forever #5 sys_clk = ~sys_clk;
   function [31:0] xs(input [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      xs = x ^ (x << 5);
   endfunction
   function [7:0] rview(input [39:0] a, input [2:0] s, input integer n);
      logic [39:0] t;
      t = $signed(a) >>> s;
      rview = t[8*n+:8];
   endfunction
   function [39:0] wview(input [39:0] m, input [2:0] s, input f);
      wview = (m << s) | ({40{f}} & ((40'h1 << s) - 40'h1));
   endfunction
   task cmp(input string n, input [39:0] e, input [39:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_sim;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task ap(input w, input [9:0] x, input [7:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {x, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge sys_clk) penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      ap(0, 10'h0E7, 0); cmp("ctl reset", 0, rd);
      ap(0, 10'h000, 0); cmp("unmapped", 0, rd);
      cmp("slverr", 1, err);
      ap(0, 10'h0E8, 0); cmp("mapped slverr", 0, err);
      // Every shift code and both fill values
      for (i = 0; i < 8; i++) begin
         rs = xs(rs);
         ctl = {1'b0, rs[9], i[2:0], ~i[2:0]};
         ap(1, 10'h0E7, ctl); #1 cmp("clear", 0, accValue);
         img = 0;
         for (k = 0; k < 5; k++) begin
            rs = xs(rs);
            img[8*k+:8] = rs[7:0];
            ap(1, 10'h0E8 + k, rs[7:0]);
         end
         #1 cmp("acc", wview(img, ctl[2:0], ctl[6]), accValue);
         for (k = 0; k < 5; k++) begin
            ap(0, 10'h0E8 + k, 0);
            cmp("rd", rview(wview(img, ctl[2:0], ctl[6]), ctl[5:3], k), rd);
         end
         ap(0, 10'h0E7, 0); cmp("ctl", ctl, rd);
      end
      for (i = 0; i < 2; i++) begin
         ap(1, 10'h0E7, {i[0], 7'h0});
         rs = xs(rs);
         v <= {rs[7:0], rs};
         gap <= rs[11:8];
         @(posedge sys_clk) go <= 1'b1;
         @(posedge sys_clk) go <= 1'b0;
         repeat (40) if (calcIrq !== 1'b1) @(posedge sys_clk);
         #1 cmp("irq", i, calcIrq);
         cmp("load", v, accValue);
         ap(0, 10'h0EC, 0); #1 cmp("irq clr", 0, calcIrq);
      end
      // Reset in mid-run must bring control and accumulator back to zero
      ap(1, 10'h0E7, 8'hFF);
      ap(1, 10'h0E8, 8'hA5);
      @(posedge sys_clk) nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 cmp("rst acc", 0, accValue);
      cmp("rst irq", 0, calcIrq);
      @(posedge sys_clk) nrst <= 1'b1;
      ap(0, 10'h0E7, 0); cmp("rst ctl", 0, rd);
      end_sim;
   end
   initial begin
      #400000;
      err_count++;
      end_sim;
   end
endmodule // mac_control_and_shift_tb
